// File: logic/fsr_pkg.sv
// fsr_pkg: constants, state codes and carriers for the flash status block.
// assumes a 25 MHz system clock shared by the host bus and the register bus.
package fsr_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_NS   = 40;
  localparam int WIN_US   = 80;                          // sector-erase add window
  localparam int PROT_US  = 100;                         // all-protected erase hold
  localparam int WIN_CYC  = (WIN_US * 1000) / CLK_NS;    // longest time: round down
  localparam int PROT_CYC = (PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W    = 20;
  localparam int WIN_W    = 12;

  // ==========================================================================
  // host bus commands and unlock addresses
  localparam logic [11:0] UNL_A1   = 12'h555;
  localparam logic [11:0] UNL_A2   = 12'haaa;
  localparam logic [7:0]  UNL_D1   = 8'haa;
  localparam logic [7:0]  UNL_D2   = 8'h55;
  localparam logic [7:0]  CMD_PROG = 8'ha0;
  localparam logic [7:0]  CMD_ERS  = 8'h80;
  localparam logic [7:0]  CMD_BULK = 8'h10;
  localparam logic [7:0]  CMD_SECT = 8'h30;              // also resume
  localparam logic [7:0]  CMD_SUSP = 8'hb0;
  localparam logic [7:0]  CMD_RST  = 8'hf0;
  localparam logic [7:0]  ERASED   = 8'hff;

  // ==========================================================================
  // array geometry
  localparam int NSEC   = 8;
  localparam int SEC_W  = 3;
  localparam int BYTE_W = 3;
  localparam int IDX_W  = SEC_W + BYTE_W;
  localparam int NBYTES = 1 << IDX_W;

  // ==========================================================================
  // status byte bit positions
  localparam int SB_POLL = 7;
  localparam int SB_TGL  = 6;
  localparam int SB_FAIL = 5;
  localparam int SB_WIN  = 3;

  // ==========================================================================
  // register map (byte addresses) and fields
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_PROT_LSB = 0;
  localparam int CTRL_INJ      = 8;
  localparam logic [7:0] PROT_RST = 8'h00;

  // ==========================================================================
  // states
  typedef enum logic [4:0] {
    OP_READ  = 5'b00001,
    OP_PROG  = 5'b00010,
    OP_ERASE = 5'b00100,
    OP_PROTW = 5'b01000,
    OP_SUSP  = 5'b10000
  } fsr_op_t;

  typedef enum logic [6:0] {
    SQ_IDLE = 7'b0000001,
    SQ_U1   = 7'b0000010,
    SQ_U2   = 7'b0000100,
    SQ_PROG = 7'b0001000,
    SQ_E3   = 7'b0010000,
    SQ_E4   = 7'b0100000,
    SQ_E5   = 7'b1000000
  } fsr_seq_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        rd;       // one-cycle read strobe
    logic        wr;       // one-cycle write strobe
    logic [11:0] addr;     // A11..A0
    logic [7:0]  wdata;
    logic [NSEC-1:0] main_sector_select;
  } fsr_host_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } fsr_avm_t;

endpackage

// File: logic/fsr_flash_status.sv
// fsr_flash_status: small flash array with embedded program/erase sequencer,
// status-byte read path and an avalon-mm control/status slave.
// assumes host strobes and selects come from logic on clk (no synchroniser).
//
// Functional notes
// - read mode after reset or reset command
// - idle array always returns stored data
// - busy array reads return status, unlimited
// - program poll bit is inverse written bit
// - erase poll bit zero until done
// - status valid after fourth/sixth command write
// - all-protected erase: poll zero, then data
// - program toggle flips per selected read
// - program done: stop toggling, return data
// - erase toggle flips until erase completes
// - all-protected erase: toggle zero, then data
// - fail bit zero normally, one on failure
// - fail on zero-to-one or cell timeout
// - fail bit cleared only by reset or reset command
// - erase window bit one after 80us
// - program only clears bits; erase whole sectors
// - one byte per program sequence
// - program into protected sector ignored
// - commands need an active sector select
// - status bit layout 7,6,5,3; others zero
// - erase-sector reads return poll and fail
// - during erase only reset, suspend and add-sector accepted
`timescale 1ns/10ps
module fsr_flash_status
  import fsr_pkg::*;
#(
  parameter int PROG_CYC  = 16,   // embedded program duration
  parameter int ERASE_CYC = 64    // embedded erase duration after last sector command
) (
  input  wire logic       clk,              // 25 MHz system clock
  input  wire logic       nrst,             // async reset, active low
  input  wire fsr_host_t  host,             // host bus request
  output logic [7:0]      host_rdata_q,     // read data or status byte
  output logic            host_rvalid_q,    // read answer strobe
  input  wire fsr_avm_t   avm,              // avalon-mm request
  output logic [31:0]     avm_readdata_q,   // avalon read data
  output logic            avm_waitrequest_q // avalon wait
);

  // ==========================================================================
  // helpers
  function automatic logic [SEC_W-1:0] sec_of(input logic [NSEC-1:0] sel);
    logic [SEC_W-1:0] r;
    r = '0;
    for (int i = NSEC - 1; i >= 0; i--) begin
      if (sel[i]) begin
        r = SEC_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic is_cmd(input logic [11:0] a, input logic [7:0] d,
                                  input logic [11:0] ea, input logic [7:0] ed);
    return (a == ea) && (d == ed);
  endfunction

  // ==========================================================================
  // state
  fsr_op_t           op_q;
  fsr_seq_t          seq_q;
  logic [TMR_W-1:0]  tmr_q;
  logic [WIN_W-1:0]  win_q;
  logic [NSEC-1:0]   ers_mask_q;
  logic [IDX_W-1:0]  prog_idx_q;
  logic [7:0]        prog_data_q;
  logic              fail_q;
  logic              tgl_q;
  logic [7:0]        mem_q [NBYTES];
  logic [NSEC-1:0]   prot_q;
  logic              inj_q;

  logic              sel_any;
  logic              wr;
  logic              rd;
  logic [IDX_W-1:0]  idx;
  logic              reset_cmd;
  logic              start_prog;
  logic              start_bulk;
  logic              start_sect;
  logic              add_sect;
  logic              suspend;
  logic              resume;
  logic              tmr_done;
  logic              prog_bad;
  logic              fail_set;
  logic              busy_status;
  logic [NSEC-1:0]   new_mask;

  // ==========================================================================
  // command events
  always_comb begin
    sel_any     = |host.main_sector_select;
    wr          = host.wr && sel_any;
    rd          = host.rd && sel_any;
    idx         = {sec_of(host.main_sector_select), host.addr[BYTE_W-1:0]};
    reset_cmd   = wr && host.wdata == CMD_RST && seq_q != SQ_PROG;
    start_prog  = wr && op_q == OP_READ && seq_q == SQ_PROG
                  && !prot_q[sec_of(host.main_sector_select)];
    start_bulk  = wr && op_q == OP_READ && seq_q == SQ_E5
                  && is_cmd(host.addr, host.wdata, UNL_A1, CMD_BULK);
    start_sect  = wr && op_q == OP_READ && seq_q == SQ_E5
                  && host.wdata == CMD_SECT;
    add_sect    = wr && op_q == OP_ERASE && host.wdata == CMD_SECT
                  && win_q != WIN_W'(WIN_CYC);
    suspend     = wr && op_q == OP_ERASE && host.wdata == CMD_SUSP;
    resume      = wr && op_q == OP_SUSP && host.wdata == CMD_SECT;
    new_mask    = start_bulk ? {NSEC{1'b1}} : host.main_sector_select;
    // a suspend or an added sector in the last timer cycle defers completion
    tmr_done    = tmr_q == TMR_W'(1) && op_q != OP_SUSP && !suspend && !add_sect;
    prog_bad    = (mem_q[prog_idx_q] & prog_data_q) != prog_data_q;
    fail_set    = tmr_done && ((op_q == OP_PROG && (prog_bad || inj_q))
                  || (op_q == OP_ERASE && inj_q));
    busy_status = op_q == OP_PROG || op_q == OP_ERASE || op_q == OP_PROTW;
  end

  // ==========================================================================
  // instruction sequence tracker, only listens in read mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_q <= SQ_IDLE;
    end else if (wr) begin
      if (op_q != OP_READ || reset_cmd) begin
        seq_q <= SQ_IDLE;
      end else begin
        case (seq_q)
          SQ_IDLE: seq_q <= is_cmd(host.addr, host.wdata, UNL_A1, UNL_D1) ? SQ_U1 : SQ_IDLE;
          SQ_U1:   seq_q <= is_cmd(host.addr, host.wdata, UNL_A2, UNL_D2) ? SQ_U2 : SQ_IDLE;
          SQ_U2: begin
            if (is_cmd(host.addr, host.wdata, UNL_A1, CMD_PROG)) begin
              seq_q <= SQ_PROG;
            end else if (is_cmd(host.addr, host.wdata, UNL_A1, CMD_ERS)) begin
              seq_q <= SQ_E3;
            end else begin
              seq_q <= SQ_IDLE;
            end
          end
          SQ_PROG: seq_q <= SQ_IDLE;
          SQ_E3:   seq_q <= is_cmd(host.addr, host.wdata, UNL_A1, UNL_D1) ? SQ_E4 : SQ_IDLE;
          SQ_E4:   seq_q <= is_cmd(host.addr, host.wdata, UNL_A2, UNL_D2) ? SQ_E5 : SQ_IDLE;
          SQ_E5:   seq_q <= SQ_IDLE;
          default: seq_q <= SQ_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // operation state and its timer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_q  <= OP_READ;
      tmr_q <= '0;
    end else if (reset_cmd) begin
      op_q  <= OP_READ;
      tmr_q <= '0;
    end else begin
      case (op_q)
        OP_READ: begin
          if (start_prog) begin
            op_q  <= OP_PROG;
            tmr_q <= TMR_W'(PROG_CYC);
          end else if ((start_bulk || start_sect) && (new_mask & ~prot_q) == '0) begin
            op_q  <= OP_PROTW;
            tmr_q <= TMR_W'(PROT_CYC);
          end else if (start_bulk || start_sect) begin
            op_q  <= OP_ERASE;
            tmr_q <= TMR_W'(ERASE_CYC);
          end
        end
        OP_PROG, OP_PROTW: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - TMR_W'(1);
          end
          if (tmr_done && !fail_set) begin
            op_q <= OP_READ;
          end
        end
        OP_ERASE: begin
          if (suspend) begin
            op_q <= OP_SUSP;
          end else if (add_sect) begin
            tmr_q <= TMR_W'(ERASE_CYC);
          end else begin
            if (tmr_q != '0) begin
              tmr_q <= tmr_q - TMR_W'(1);
            end
            if (tmr_done && !fail_set) begin
              op_q <= OP_READ;
            end
          end
        end
        OP_SUSP: begin
          if (resume) begin
            op_q <= OP_ERASE;
          end
        end
        default: begin
          op_q <= OP_READ;
        end
      endcase
    end
  end

  // ==========================================================================
  // erase target mask and add-sector window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ers_mask_q <= '0;
      win_q      <= '0;
    end else if (start_sect || add_sect) begin
      ers_mask_q <= (start_sect ? '0 : ers_mask_q) | new_mask;
      win_q      <= '0;
    end else if (start_bulk) begin
      ers_mask_q <= new_mask;
      win_q      <= WIN_W'(WIN_CYC);   // bulk erase takes no additions
    end else if (win_q != WIN_W'(WIN_CYC)) begin
      win_q      <= win_q + WIN_W'(1);
    end
  end

  // ==========================================================================
  // program target latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_idx_q  <= '0;
      prog_data_q <= ERASED;
    end else if (start_prog) begin
      prog_idx_q  <= idx;
      prog_data_q <= host.wdata;
    end
  end

  // ==========================================================================
  // fail flag: a failure in the same cycle as a reset command still sets it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_q <= 1'b0;
    end else if (fail_set) begin
      fail_q <= 1'b1;
    end else if (reset_cmd) begin
      fail_q <= 1'b0;
    end
  end

  // ==========================================================================
  // array storage; failed programs still pull bits low, as real cells would
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem_q[i] <= ERASED;
      end
    end else if (tmr_done && op_q == OP_PROG) begin
      mem_q[prog_idx_q] <= mem_q[prog_idx_q] & prog_data_q;
    end else if (tmr_done && op_q == OP_ERASE && !inj_q) begin
      for (int i = 0; i < NBYTES; i++) begin
        if (ers_mask_q[i >> BYTE_W] && !prot_q[i >> BYTE_W]) begin
          mem_q[i] <= ERASED;
        end
      end
    end
  end

  // ==========================================================================
  // host read path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tgl_q <= 1'b0;
    end else if (rd && (op_q == OP_PROG || op_q == OP_ERASE)) begin
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_rvalid_q <= 1'b0;
      host_rdata_q  <= '0;
    end else begin
      host_rvalid_q <= rd;
      if (rd) begin
        if (busy_status) begin
          host_rdata_q          <= '0;
          host_rdata_q[SB_POLL] <= (op_q == OP_PROG) && !prog_data_q[SB_POLL];
          host_rdata_q[SB_TGL]  <= (op_q != OP_PROTW) && tgl_q;
          host_rdata_q[SB_FAIL] <= fail_q;
          host_rdata_q[SB_WIN]  <= win_q == WIN_W'(WIN_CYC);
        end else begin
          host_rdata_q          <= mem_q[idx];
        end
      end
    end
  end

  // ==========================================================================
  // avalon-mm slave: one wait cycle, then the answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avm_waitrequest_q <= 1'b1;
    end else if ((avm.read || avm.write) && avm_waitrequest_q) begin
      avm_waitrequest_q <= 1'b0;
    end else begin
      avm_waitrequest_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prot_q <= PROT_RST;
      inj_q  <= 1'b0;
    end else if (avm.write && !avm_waitrequest_q && avm.address == REG_CTRL) begin
      prot_q <= avm.writedata[CTRL_PROT_LSB +: NSEC];
      inj_q  <= avm.writedata[CTRL_INJ];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avm_readdata_q <= '0;
    end else if (avm.read && avm_waitrequest_q) begin
      case (avm.address)
        REG_CTRL:   avm_readdata_q <= {23'h0, inj_q, prot_q};
        REG_STATUS: avm_readdata_q <= {16'h0, ers_mask_q, 2'h0, tgl_q,
                                       op_q == OP_PROTW, op_q == OP_SUSP,
                                       win_q == WIN_W'(WIN_CYC), fail_q,
                                       op_q != OP_READ};
        default:    avm_readdata_q <= '0;
      endcase
    end
  end

endmodule

// File: dv/fsr_flash_status_props.sv
// fsr_flash_status_props: port-level checks for the flash status block.
// assumes one clock domain; attached by bind at the foot of this file.
`timescale 1ns/10ps
module fsr_flash_status_props
  import fsr_pkg::*;
(
  input wire logic        clk,               // system clock
  input wire logic        nrst,              // async reset, active low
  input wire fsr_host_t   host,              // host request
  input wire logic [7:0]  host_rdata_q,      // read byte
  input wire logic        host_rvalid_q,     // read strobe
  input wire fsr_avm_t    avm,               // avalon request
  input wire logic [31:0] avm_readdata_q,    // avalon read data
  input wire logic        avm_waitrequest_q  // avalon wait
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // host read path
  chk_reset_quiet: assert property ($rose(nrst) |-> !host_rvalid_q && host_rdata_q == 8'h00)
    else $error("outputs not at reset values after release");
  chk_read_answer: assert property (host.rd && |host.main_sector_select |=> host_rvalid_q)
    else $error("taken read got no answer strobe");
  chk_no_spurious: assert property (!(host.rd && |host.main_sector_select) |=> !host_rvalid_q)
    else $error("answer strobe without a selected read");
  chk_rdata_hold: assert property (!host_rvalid_q |-> $stable(host_rdata_q))
    else $error("read byte changed without an answer");
  // ==========================================================================
  // register bus
  chk_wait_answer: assert property ((avm.read || avm.write) && avm_waitrequest_q |=> !avm_waitrequest_q)
    else $error("waitrequest not dropped one cycle after request");
  chk_wait_one: assert property (!avm_waitrequest_q |=> avm_waitrequest_q)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle: assert property (!(avm.read || avm.write) |=> avm_waitrequest_q)
    else $error("waitrequest low with no request");
  chk_rdata_stable: assert property (avm_waitrequest_q |-> $stable(avm_readdata_q))
    else $error("avalon read data moved outside an answer");
endmodule

bind fsr_flash_status fsr_flash_status_props i_props (
  .clk(clk), .nrst(nrst), .host(host), .host_rdata_q(host_rdata_q),
  .host_rvalid_q(host_rvalid_q), .avm(avm), .avm_readdata_q(avm_readdata_q),
  .avm_waitrequest_q(avm_waitrequest_q));

// File: dv/fsr_host_model.sv
// fsr_host_model: byte-wide host core issuing flash sequences and reads.
// assumes one-cycle strobes; select held between strobes of a sequence.
`timescale 1ns/10ps
module fsr_host_model
  import fsr_pkg::*;
(
  input  wire logic       clk,           // system clock
  output fsr_host_t       host,          // request to the flash
  input  wire logic [7:0] host_rdata_q,  // answer byte
  input  wire logic       host_rvalid_q  // answer strobe
);
  initial host = '0;
  // released address and data show the inverse, never the stale value
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] s);
    @(posedge clk);
    host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, main_sector_select: s};
    @(posedge clk);
    host <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, main_sector_select: s};
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] s, output logic [7:0] q,
                    output logic ok);
    int k;
    @(posedge clk);
    host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00, main_sector_select: s};
    @(posedge clk);
    host <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff, main_sector_select: s};
    ok = 1'b0;
    q = 8'h00;
    for (k = 0; k < 3 && !ok; k++) begin
      @(posedge clk);
      if (host_rvalid_q === 1'b1) begin
        ok = 1'b1;
        q = host_rdata_q;
      end
    end
  endtask
  task automatic unlock(input logic [7:0] s);
    wr(UNL_A1, UNL_D1, s);
    wr(UNL_A2, UNL_D2, s);
  endtask
  task automatic prog(input logic [11:0] a, input logic [7:0] d, input logic [7:0] s);
    unlock(s);
    wr(UNL_A1, CMD_PROG, s);
    wr(a, d, s);
  endtask
  // single sector command only: no sector is added inside the window
  task automatic erase(input logic [11:0] a, input logic [7:0] c, input logic [7:0] s);
    unlock(s);
    wr(UNL_A1, CMD_ERS, s);
    unlock(s);
    wr(a, c, s);
  endtask
endmodule

// File: dv/tb.sv
// tb: self-checking bench for fsr_flash_status driven by the host model.
// assumes short program time and an erase longer than the add window.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb
  import fsr_pkg::*;
;
  localparam int P_CYC = 16;
  localparam int E_CYC = 2200;  // outlasts the window so it can close mid-erase
  logic        clk;
  logic        nrst;
  fsr_host_t   host;
  logic [7:0]  rdata;
  logic        rvalid;
  fsr_avm_t    avm;
  logic [31:0] avm_rdata;
  logic        avm_wait;
  int          n_fail;
  int          samples_checked;
  logic [7:0]  q;
  logic [7:0]  q2;
  logic        ok;
  logic [31:0] w;

  fsr_flash_status #(.PROG_CYC(P_CYC), .ERASE_CYC(E_CYC)) i_dut (
    .clk(clk), .nrst(nrst), .host(host), .host_rdata_q(rdata), .host_rvalid_q(rvalid),
    .avm(avm), .avm_readdata_q(avm_rdata), .avm_waitrequest_q(avm_wait));
  fsr_host_model i_host (.clk(clk), .host(host), .host_rdata_q(rdata), .host_rvalid_q(rvalid));

  // ==========================================================================
  // shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avm <= '{read: !wr, write: wr, address: a, writedata: d};
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      if (avm_wait === 1'b0) break;
    end
    w = avm_rdata;
    avm <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d};
    if (k == 8) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] s,
                      input logic [7:0] e, input logic [7:0] m);
    i_host.rd(a, s, q, ok);
    `CHK(nm, 1'b1, ok)
    `CHK(nm, e & m, q & m)
  endtask
  task automatic poll(input logic [11:0] a, input logic [7:0] s, input logic [7:0] e);
    int k;
    for (k = 0; k < 1200; k++) begin
      i_host.rd(a, s, q, ok);
      if (q === e) break;  // stop at the first match; the byte is then read once more
    end
    `CHK("poll end", e, q)
    i_host.rd(a, s, q2, ok);
    `CHK("steady reread", e, q2)
    if (k == 1200) complete_run();
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_idle();
    rchk("erased byte", 12'h003, 8'h01, ERASED, 8'hff);
    reg_acc(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl reset", {24'h0, PROT_RST}, w & 32'h1ff)
    reg_acc(1'b1, 4'hc, 32'hffff_ffff);
    reg_acc(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, w)
    i_host.rd(12'h003, 8'h00, q, ok);
    `CHK("unselected read", 1'b0, ok)
    i_host.prog(12'h004, 8'h00, 8'h00);
    rchk("unselected prog", 12'h004, 8'h01, ERASED, 8'hff);
    $display("test idle done");
  endtask
  task automatic t_prog();
    i_host.prog(12'h002, 8'h5a, 8'h02);
    rchk("prog status", 12'h002, 8'h02, 8'h80, 8'hb7);
    q2 = q;
    rchk("prog status", 12'h005, 8'h02, 8'h80, 8'hb7);
    `CHK("toggle flip", ~q2[6], q[6])
    poll(12'h002, 8'h02, 8'h5a);
    i_host.prog(12'h002, 8'h0a, 8'h02);
    poll(12'h002, 8'h02, 8'h0a);
    $display("test program done");
  endtask
  task automatic t_fail();
    i_host.prog(12'h002, 8'hf0, 8'h02);
    repeat (P_CYC + 4) @(posedge clk);
    rchk("fail status", 12'h002, 8'h02, 8'h20, 8'hb7);
    rchk("fail held", 12'h002, 8'h02, 8'h20, 8'hb7);
    i_host.wr(12'h000, CMD_RST, 8'h02);
    rchk("after reset cmd", 12'h002, 8'h02, 8'h00, 8'hff);
    $display("test fail done");
  endtask
  task automatic t_prot();
    i_host.prog(12'h001, 8'h3c, 8'h04);
    poll(12'h001, 8'h04, 8'h3c);
    reg_acc(1'b1, REG_CTRL, 32'h4);
    i_host.prog(12'h001, 8'h00, 8'h04);
    rchk("protected prog", 12'h001, 8'h04, 8'h3c, 8'hff);
    i_host.erase(12'h000, CMD_SECT, 8'h04);
    rchk("prot erase", 12'h001, 8'h04, 8'h00, 8'hc0);
    rchk("prot erase", 12'h001, 8'h04, 8'h00, 8'hc0);
    poll(12'h001, 8'h04, 8'h3c);
    reg_acc(1'b1, REG_CTRL, 32'h0);
    $display("test protect done");
  endtask
  task automatic t_serase();
    i_host.erase(12'h000, CMD_SECT, 8'h02);
    rchk("erase status", 12'h002, 8'h02, 8'h00, 8'hbf);
    q2 = q;
    rchk("erase status", 12'h006, 8'h02, 8'h00, 8'hbf);
    `CHK("erase toggle", ~q2[6], q[6])
    repeat (WIN_CYC) @(posedge clk);
    rchk("window closed", 12'h002, 8'h02, 8'h08, 8'hbf);
    i_host.prog(12'h001, 8'h00, 8'h04);
    poll(12'h002, 8'h02, ERASED);
    rchk("prog during erase", 12'h001, 8'h04, 8'h3c, 8'hff);
    rchk("other sector", 12'h001, 8'h04, 8'h3c, 8'hff);
    $display("test sector erase done");
  endtask
  task automatic t_bulk();
    i_host.erase(UNL_A1, CMD_BULK, 8'h01);
    rchk("bulk status", 12'h000, 8'h01, 8'h08, 8'hbf);
    poll(12'h001, 8'h04, ERASED);
    $display("test bulk erase done");
  endtask
  task automatic t_susp();
    i_host.prog(12'h000, 8'h80, 8'h08);
    poll(12'h000, 8'h08, 8'h80);
    i_host.erase(12'h000, CMD_SECT, 8'h02);
    i_host.wr(12'h000, CMD_SECT, 8'h08); // second sector inside the window
    i_host.wr(12'h000, CMD_SUSP, 8'h02);
    rchk("suspended read", 12'h000, 8'h08, 8'h80, 8'hff);
    reg_acc(1'b0, REG_STATUS, 32'h0);
    `CHK("status reg", 32'h0000_0a09, w & 32'hffff_ffdf)
    i_host.wr(12'h000, CMD_SECT, 8'h02);
    poll(12'h000, 8'h08, ERASED);
    $display("test suspend done");
  endtask
  task automatic t_mreset();
    i_host.prog(12'h002, 8'h00, 8'h02);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk("module reset", 12'h002, 8'h02, ERASED, 8'hff);
    $display("test module reset done");
  endtask

  // ==========================================================================
  // clock, sequence, watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    avm = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_idle();
    t_prog();
    t_fail();
    t_prot();
    t_serase();
    t_bulk();
    t_susp();
    t_mreset();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
